// ---- modem_pins.sv ----
// pin logic of the two serial ports' modem-control interface
// assumes a uart core supplies control values and drains status words
// assumes the modem pins arrive unsynchronised; two stages settle them
`timescale 1ns/100ps
`include "modem_pins_defines.svh"
module modem_pins #(
    parameter int PORTS = 2
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic main_power_off_in,
    input wire logic [PORTS-1:0] cts_n_in,
    input wire logic [PORTS-1:0] dcd_n_in,
    input wire logic [PORTS-1:0] dsr_n_in,
    input wire logic [PORTS-1:0] ri_n_in,
    input wire logic [PORTS-1:0] sin_in,
    input wire modem_pins_pkg::control_t [PORTS-1:0] ctrl_in,
    output logic [PORTS-1:0] rts_n_out,
    output logic [PORTS-1:0] terminal_ready_or_baud_pin_out,
    output logic [PORTS-1:0] sout_out,
    output logic [PORTS-1:0] wake_up_out,
    output logic [PORTS-1:0] status_valid_out,
    input wire logic [PORTS-1:0] status_ready_in,
    output modem_pins_pkg::status_t [PORTS-1:0] status_out
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration check: the logic needs at least one port to serve
    if (PORTS < 1) begin : g_bad_ports
        $error("modem_pins needs at least one port");
    end

    ////////////////////////////////////////////////////////////////////////
    // every flip-flop of the block outside the status buffers lives in this one record
    typedef struct packed {
        // two-stage synchroniser; only the second stage is ever decoded
        modem_pins_pkg::status_t [PORTS-1:0] sync1;
        modem_pins_pkg::status_t [PORTS-1:0] sync2;
        // the word most recently handed to the status buffer
        modem_pins_pkg::status_t [PORTS-1:0] last;
        // output pin levels, registered so no decode glitch reaches a pin
        logic [PORTS-1:0] rts_n;
        logic [PORTS-1:0] dtr_pin;
        logic [PORTS-1:0] sout;
        // wake-up levels, one per port
        logic [PORTS-1:0] wake;
    } pins_state_t;
    pins_state_t st_r;
    pins_state_t st_nxt;

    // active-high view of the pins
    modem_pins_pkg::status_t [PORTS-1:0] sample;

    // decoded control of each port
    logic [PORTS-1:0] test_mode;
    logic [PORTS-1:0] loop_on;

    // next pin levels, one bit per port
    logic [PORTS-1:0] rts_n_nxt;
    logic [PORTS-1:0] dtr_nxt;
    logic [PORTS-1:0] sout_nxt;

    // wake-up path
    logic [PORTS-1:0] ring_seen;
    logic [PORTS-1:0] wake_nxt;

    // status words and the handshake towards their buffers
    modem_pins_pkg::status_t [PORTS-1:0] word;
    modem_pins_pkg::status_t [PORTS-1:0] last_nxt;
    logic [PORTS-1:0] push;
    logic [PORTS-1:0] buf_ready;
    logic [PORTS-1:0] can_push;

    ////////////////////////////////////////////////////////////////////////
    // per-port logic: polarity, pin priority, wake-up and status words
    generate
        for (genvar g = 0; g < PORTS; g++) begin : g_port
            // status pins are active low; flip them once, pass serial in as is, so all logic is active high
            assign sample[g] = {~cts_n_in[g], ~dcd_n_in[g], ~dsr_n_in[g],
                                ~ri_n_in[g], sin_in[g]};

            // control fields that choose what the pins carry
            assign test_mode[g] =
                ctrl_in[g].extended_control_register[`CTRL_TEST_BIT];
            assign loop_on[g] = ctrl_in[g].loopback;

            // request to send: active low, held inactive in loopback
            assign rts_n_nxt[g] = loop_on[g]
                ? `PIN_INACTIVE
                : ~ctrl_in[g].request_to_send;

            // shared pin: test mode beats loopback, loopback beats ready;
            // test mode wins so the baud clock stays visible in loopback
            assign dtr_nxt[g] = test_mode[g]
                ? ctrl_in[g].baud_rate_test_output
                : loop_on[g]
                ? `PIN_INACTIVE
                : ~ctrl_in[g].terminal_ready;

            // loopback keeps the line idle so the far end sees no data
            assign sout_nxt[g] = loop_on[g]
                ? `PIN_INACTIVE
                : ctrl_in[g].serial_out;

            // only the settled ring bit counts; the first stage may be torn
            assign ring_seen[g] = main_power_off_in && st_r.sync2[g].ring;
            // a ring sets wake, which then holds until main power returns
            assign wake_nxt[g] = ring_seen[g]
                || (main_power_off_in && st_r.wake[g]);

            // a word is due whenever the settled sample leaves the last one
            assign word[g] = st_r.sync2[g];
            assign push[g] = (st_r.sync2[g] != st_r.last[g]);
            assign can_push[g] = push[g] && buf_ready[g];

            // a full buffer leaves last alone, so the word is offered again;
            // changes in the meantime merge into one newer word
            assign last_nxt[g] = can_push[g] ? st_r.sync2[g] : st_r.last[g];

            // two entries per port hold two changes for a stalled core; later ones merge
            status_buffer #(
                .WIDTH($bits(modem_pins_pkg::status_t))
            ) u_buf (
                .clk_in(clk_in),
                .sys_rst_in(sys_rst_in),
                .in_valid_in(push[g]),
                .in_ready_out(buf_ready[g]),
                .in_data_in(word[g]),
                .out_valid_out(status_valid_out[g]),
                .out_ready_in(status_ready_in[g]),
                .out_data_out(status_out[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state gathered from the per-port values
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync1 = sample;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.last = last_nxt;
        st_nxt.rts_n = rts_n_nxt;
        st_nxt.dtr_pin = dtr_nxt;
        st_nxt.sout = sout_nxt;
        st_nxt.wake = wake_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // reset drives every output pin except wake-up to its inactive high level; wake-up resets low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r.sync1 <= '0;
            st_r.sync2 <= '0;
            st_r.last <= '0;
            st_r.rts_n <= '1;
            st_r.dtr_pin <= '1;
            st_r.sout <= '1;
            st_r.wake <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs come straight from flip-flops, nothing decodes after them
    assign rts_n_out = st_r.rts_n;
    assign terminal_ready_or_baud_pin_out = st_r.dtr_pin;
    assign sout_out = st_r.sout;
    assign wake_up_out = st_r.wake;
endmodule : modem_pins

// ---- modem_pins_defines.svh ----
// constants for the modem-control pin block of the two serial ports
// assumes a single 20 MHz clock and an active-high asynchronous reset
//
// Contract
// - after reset the shared pin is terminal ready, driven inactive high.
// - request-to-send is active low and goes inactive high at reset.
// - loopback holds request-to-send and terminal ready high; with control bit 7 set the shared pin carries the baud clock instead.
// - control bit 7 set routes the baud generator onto the shared pin.
// - ring inputs stay watched while main power is off; raise wake-up.
// - serial data outputs sit idle high after reset.
`ifndef MODEM_PINS_DEFINES_SVH
`define MODEM_PINS_DEFINES_SVH
`define CTRL_TEST_BIT 7
`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00
`define PIN_INACTIVE 1'b1
`define SYNC_STAGES 2
`define BUF_DEPTH 2
`endif

// ---- modem_pins_pkg.sv ----
// types for the modem-control pin block
// assumes modem_pins_defines.svh is in the include path
package modem_pins_pkg;
    // synchronised, active-high view of one port's status inputs
    typedef struct packed {
        logic clear_to_send;
        logic carrier_detect;
        logic set_ready;
        logic ring;
        logic serial_in;
    } status_t;
    // control request from the uart core, active high
    typedef struct packed {
        logic terminal_ready;
        logic request_to_send;
        logic loopback;
        logic [7:0] extended_control_register;
        logic serial_out;
        logic baud_rate_test_output;
    } control_t;
endpackage : modem_pins_pkg

// ---- status_buffer.sv ----
// two-entry valid/ready buffer for status words
// assumes one clock domain
`timescale 1ns/100ps
module status_buffer #(
    parameter int WIDTH = 5
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } buf_state_t;
    buf_state_t st_r;
    buf_state_t st_nxt;
    logic push;
    logic pop;

    // elaboration check: a word needs at least one bit
    if (WIDTH < 1) begin : g_bad_width
        $error("status_buffer width must be positive");
    end

    // flags straight from the count; data from the entry at the read side
    assign in_ready_out = (st_r.cnt != 2'h2);
    assign out_valid_out = (st_r.cnt != 2'h0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = st_r.mem[st_r.rd];

    // pointer and count update; full stalls the writer
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data_in;
            st_nxt.wr = ~st_r.wr;
        end
        if (pop) begin
            st_nxt.rd = ~st_r.rd;
        end
        st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : status_buffer

// ---- modem_pins_chk.sv ----
// assertions on the modem pin block, port 0 watched
// assumes it is bound into modem_pins and sees its ports
`timescale 1ns/100ps
module modem_pins_chk #(
    parameter int PORTS = 2
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic main_power_off_in,
    input wire logic [PORTS-1:0] cts_n_in,
    input wire logic [PORTS-1:0] ri_n_in,
    input wire modem_pins_pkg::control_t [PORTS-1:0] ctrl_in,
    input wire logic [PORTS-1:0] rts_n_out,
    input wire logic [PORTS-1:0] terminal_ready_or_baud_pin_out,
    input wire logic [PORTS-1:0] sout_out,
    input wire logic [PORTS-1:0] wake_up_out,
    input wire logic [PORTS-1:0] status_valid_out,
    input wire modem_pins_pkg::status_t [PORTS-1:0] status_out
);
    // short names for port 0
    modem_pins_pkg::control_t c;
    logic pin;
    logic t7;
    assign c = ctrl_in[0];
    assign pin = terminal_ready_or_baud_pin_out[0];
    assign t7 = c.extended_control_register[7];
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////
    // pins answer their control one edge later; test bit beats loopback
    chk_reset_idle:
    assert property ($fell(sys_rst_in) |-> rts_n_out[0] && pin
        && sout_out[0]) else $error("outputs not idle after reset");
    chk_rts_level:
    assert property (!c.loopback |=> rts_n_out[0] ==
        !$past(c.request_to_send)) else $error("rts level wrong");
    chk_dtr_level:
    assert property (!t7 |=> pin == ($past(c.loopback)
        || !$past(c.terminal_ready))) else $error("dtr level wrong");
    chk_loop_hold:
    assert property (c.loopback |=> rts_n_out[0] && sout_out[0])
        else $error("loopback let rts drop");
    chk_baud_route:
    assert property (t7 |=> pin == $past(c.baud_rate_test_output))
        else $error("baud not on shared pin");
    chk_sout_follow:
    assert property (!c.loopback |=> sout_out[0] == $past(c.serial_out))
        else $error("serial out wrong");
    // a ring held through the synchroniser must wake within two edges
    chk_wake_ring:
    assert property ((main_power_off_in && !ri_n_in[0]) [*3] |->
        ##[0:2] wake_up_out[0]) else $error("ring did not wake");
    chk_wake_clear:
    assert property (!main_power_off_in |=> !wake_up_out[0])
        else $error("wake held with power on");
    chk_status_sync:
    assert property ($fell(cts_n_in[0]) && !status_valid_out[0] |->
        !status_valid_out[0] [*3] ##1 status_valid_out[0]
        && status_out[0].clear_to_send) else $error("status latency");
    cover property (c.loopback ##1 rts_n_out[0]);
    cover property (t7 ##1 $changed(pin));
    cover property ($rose(wake_up_out[0]));
endmodule : modem_pins_chk
bind modem_pins modem_pins_chk #(.PORTS(PORTS)) u_chk (.clk_in,
    .sys_rst_in, .main_power_off_in, .cts_n_in, .ri_n_in, .ctrl_in,
    .rts_n_out, .terminal_ready_or_baud_pin_out, .sout_out,
    .wake_up_out, .status_valid_out, .status_out);

// ---- modem_far_end.sv ----
// far-end modem model driving the status lines
// assumes active-high wishes from the bench, one per port
`timescale 1ns/100ps
module modem_far_end #(
    parameter int PORTS = 2
) (
    input wire modem_pins_pkg::status_t [PORTS-1:0] want_in,
    output logic [PORTS-1:0] cts_n_out,
    output logic [PORTS-1:0] dcd_n_out,
    output logic [PORTS-1:0] dsr_n_out,
    output logic [PORTS-1:0] ri_n_out,
    output logic [PORTS-1:0] sin_out
);
    // status lines are pulled low to assert; data passes unchanged
    always_comb begin
        for (int i = 0; i < PORTS; i++) begin
            cts_n_out[i] = !want_in[i].clear_to_send;
            dcd_n_out[i] = !want_in[i].carrier_detect;
            dsr_n_out[i] = !want_in[i].set_ready;
            ri_n_out[i] = !want_in[i].ring;
            sin_out[i] = want_in[i].serial_in;
        end
    end
endmodule : modem_far_end

// ---- uart_modem_pin_control_tb.sv ----
// self-checking bench for the modem pin block
// assumes modem_pins, its checker and the far-end model
`timescale 1ns/100ps
`define CHECK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", n, e, g); end end
module uart_modem_pin_control_tb;
    logic clk, rst, pwr_off;
    modem_pins_pkg::control_t [1:0] ctrl;
    modem_pins_pkg::status_t [1:0] want, stat;
    logic [1:0] rdy, cts_n, dcd_n, dsr_n, ri_n, sin;
    logic [1:0] rts_n, pin, sout, wake, valid;
    int miscompares = 0;
    int cmp_count = 0;
    modem_pins u_dut (.clk_in(clk), .sys_rst_in(rst),
        .main_power_off_in(pwr_off), .cts_n_in(cts_n), .dcd_n_in(dcd_n),
        .dsr_n_in(dsr_n), .ri_n_in(ri_n), .sin_in(sin), .ctrl_in(ctrl),
        .rts_n_out(rts_n), .terminal_ready_or_baud_pin_out(pin),
        .sout_out(sout), .wake_up_out(wake), .status_valid_out(valid),
        .status_ready_in(rdy), .status_out(stat));
    modem_far_end u_far (.want_in(want), .cts_n_out(cts_n),
        .dcd_n_out(dcd_n), .dsr_n_out(dsr_n), .ri_n_out(ri_n),
        .sin_out(sin));
    ////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic t_drive;
        for (int i = 0; i < 4; i++) begin
            ctrl[0].extended_control_register = 8'h40; // bit 6 is no test
            ctrl[0].request_to_send = i[0];
            ctrl[0].terminal_ready = i[1];
            ctrl[0].serial_out = i[1];
            ctrl[1] = ctrl[0];
            step(1);
            `CHECK("rts", {2{~i[0]}}, rts_n)
            `CHECK("dtr", {2{~i[1]}}, pin)
            `CHECK("sout", {2{i[1]}}, sout)
        end
    endtask : t_drive
    // only port 0 loops; port 1 keeps driving its active levels
    task automatic t_loop;
        ctrl[0].loopback = 1'b1;
        ctrl[0].serial_out = 1'b0;
        step(1);
        `CHECK("loop", 4'h5, {rts_n, pin})
    endtask : t_loop
    task automatic t_baud;
        ctrl[0].extended_control_register = 8'h80;
        for (int b = 0; b < 2; b++) begin
            ctrl[0].baud_rate_test_output = b[0];
            step(1);
            `CHECK("baud", b[0], pin[0])
        end
    endtask : t_baud
    task automatic pop(input logic [4:0] exp);
        `CHECK("word", {1'b1, exp}, {valid[0], stat[0]})
        rdy[0] = 1'b1;
        step(1);
        rdy[0] = 1'b0;
        step(4);
    endtask : pop
    // three changes against a stalled reader: the third must wait
    task automatic t_status;
        rdy[0] = 1'b0;
        want[0].clear_to_send = 1'b1;
        step(5);
        want[0].carrier_detect = 1'b1;
        step(5);
        want[0].set_ready = 1'b1;
        step(5);
        pop(5'h11);
        pop(5'h19);
        pop(5'h1D);
        `CHECK("empty", 1'b0, valid[0])
    endtask : t_status
    task automatic t_wake;
        pwr_off = 1'b1;
        want[0].ring = 1'b1;
        step(6);
        `CHECK("wake", 2'h1, wake)
        pwr_off = 1'b0;
        step(4);
        `CHECK("awake", 2'h0, wake)
    endtask : t_wake
    task automatic complete_run;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // the run needs about 60 cycles; 800 means a hang
    initial begin
        repeat (800) @(posedge clk);
        miscompares++;
        complete_run;
    end
    initial begin
        rst = 1'b1;
        pwr_off = 1'b0;
        rdy = 2'h3;
        ctrl = '0;
        ctrl[0].serial_out = 1'b1;
        ctrl[1].serial_out = 1'b1;
        want = {2{5'h01}};
        step(7);
        `CHECK("reset", 6'h3F, {rts_n, pin, sout})
        step(1);
        rst = 1'b0;
        step(4);
        `CHECK("idle", 2'h3, sout)
        t_drive;
        t_loop;
        t_baud;
        t_status;
        t_wake;
        complete_run;
    end
endmodule : uart_modem_pin_control_tb
